// ### rtl/card_atr_sender.sv
// Card side answer-to-reset sender with supply class advertisement
//
// What this block does
// - Card times everything from terminal clock
// - Class byte bits 0..4 mark classes A..E
// - Several supported classes must be adjacent
// - First bytes after every reset: answer-to-reset
// - Answer always holds the T=15 global group
`default_nettype none
module card_atr_sender #(
   parameter int ETU = card_atr_pkg::ETU_CLK,
   parameter int DELAY = card_atr_pkg::ATR_DELAY_CLK
) (
   // System
   input wire logic CLK,
   input wire logic RST_B,
   // Card contacts
   input wire logic CARD_CLK,
   input wire logic CARD_RST_B,
   input wire logic IO_IN,
   output logic IO_OUT,
   output logic IO_OE,
   // AXI4-Lite write
   input wire logic [3:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   // AXI4-Lite read
   input wire logic [3:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY
);
   // Pin synchronisers, third stage only for edge finding
   logic [2:0] cclk_sync_reg;
   logic [1:0] crst_sync_reg;
   logic [1:0] io_sync_reg;
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         cclk_sync_reg <= 3'h0;
         crst_sync_reg <= 2'h0;
         io_sync_reg <= 2'h3;
      end else begin
         cclk_sync_reg <= {cclk_sync_reg[1:0], CARD_CLK};
         crst_sync_reg <= {crst_sync_reg[0], CARD_RST_B};
         io_sync_reg <= {io_sync_reg[0], IO_IN};
      end
   end
   logic clk_rise;
   logic card_rst_b_s;
   assign clk_rise = cclk_sync_reg[1] & ~cclk_sync_reg[2];
   assign card_rst_b_s = crst_sync_reg[1];

   // Non-empty run of adjacent ones: adding lowest one clears the run
   function automatic logic class_legal(input logic [4:0] v);
      logic [5:0] sum;
      sum = {1'b0, v} + {1'b0, v & (~v + 5'h01)};
      class_legal = (v != 5'h00) && ((sum[4:0] & v) == 5'h00);
   endfunction

   // Frame bit of the current character
   function automatic logic frame_bit(input logic [7:0] d, input logic [3:0] b);
      if (b == 4'h0) begin
         frame_bit = 1'b0;
      end else if (b <= 4'h8) begin
         frame_bit = d[3'(b - 4'h1)];
      end else if (b == 4'(card_atr_pkg::PARITY_BIT)) begin
         frame_bit = ^d;
      end else begin
         frame_bit = 1'b1;
      end
   endfunction

   // Register bus state
   logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
   logic [3:0] aw_addr_reg, aw_addr_next;
   logic [31:0] w_data_reg, w_data_next;
   logic w_strb0_reg, w_strb0_next;
   logic awready_reg, awready_next, wready_reg, wready_next;
   logic bvalid_reg, bvalid_next, arready_reg, arready_next, rvalid_reg, rvalid_next;
   logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [4:0] class_reg, class_next;
   logic rejected_reg, rejected_next;
   card_atr_pkg::atr_state_t state_reg, state_next;
   card_atr_pkg::status_t status;
   assign status = '{io_line: io_sync_reg[1], rejected: rejected_reg,
                     done: state_reg == card_atr_pkg::ST_DONE,
                     busy: state_reg == card_atr_pkg::ST_WAIT ||
                           state_reg == card_atr_pkg::ST_SEND};

   // Bus slave: address and data in either order, one answer each
   always_comb begin
      logic do_write, set_rej;
      do_write = 1'b0;
      set_rej = 1'b0;
      aw_hold_next = aw_hold_reg;
      aw_addr_next = aw_addr_reg;
      w_hold_next = w_hold_reg;
      w_data_next = w_data_reg;
      w_strb0_next = w_strb0_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      arready_next = arready_reg;
      rvalid_next = rvalid_reg;
      rresp_next = rresp_reg;
      rdata_next = rdata_reg;
      class_next = class_reg;
      rejected_next = rejected_reg;
      if (S_AXI_AWVALID && awready_reg) begin
         aw_hold_next = 1'b1;
         aw_addr_next = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && wready_reg) begin
         w_hold_next = 1'b1;
         w_data_next = S_AXI_WDATA;
         w_strb0_next = S_AXI_WSTRB[0];
      end
      if (bvalid_reg && S_AXI_BREADY) begin
         bvalid_next = 1'b0;
      end
      if (aw_hold_reg && w_hold_reg && !bvalid_reg) begin
         do_write = 1'b1;
         aw_hold_next = 1'b0;
         w_hold_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = card_atr_pkg::RESP_OKAY;
      end
      if (do_write && aw_addr_reg == card_atr_pkg::CLASS_ADDR) begin
         if (w_strb0_reg && class_legal(w_data_reg[4:0])) begin
            class_next = w_data_reg[4:0];
         end else if (w_strb0_reg) begin
            set_rej = 1'b1;
         end
      end else if (do_write && aw_addr_reg == card_atr_pkg::STATUS_ADDR) begin
         if (w_strb0_reg && w_data_reg[2]) begin
            rejected_next = 1'b0;
         end
      end else if (do_write) begin
         bresp_next = card_atr_pkg::RESP_SLVERR;
      end
      if (set_rej) begin
         rejected_next = 1'b1; // Set wins over clear
      end
      if (rvalid_reg && S_AXI_RREADY) begin
         rvalid_next = 1'b0;
      end
      if (S_AXI_ARVALID && arready_reg) begin
         rvalid_next = 1'b1;
         rresp_next = card_atr_pkg::RESP_OKAY;
         if (S_AXI_ARADDR == card_atr_pkg::CLASS_ADDR) begin
            rdata_next = {27'h0, class_reg};
         end else if (S_AXI_ARADDR == card_atr_pkg::STATUS_ADDR) begin
            rdata_next = {28'h0, status};
         end else begin
            rdata_next = 32'h0;
            rresp_next = card_atr_pkg::RESP_SLVERR;
         end
      end
      arready_next = !rvalid_next;
      awready_next = !aw_hold_next;
      wready_next = !w_hold_next;
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         aw_hold_reg <= 1'b0;
         aw_addr_reg <= 4'h0;
         w_hold_reg <= 1'b0;
         w_data_reg <= 32'h0;
         w_strb0_reg <= 1'b0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= 2'h0;
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rresp_reg <= 2'h0;
         rdata_reg <= 32'h0;
         class_reg <= card_atr_pkg::CLASS_RST;
         rejected_reg <= 1'b0;
      end else begin
         aw_hold_reg <= aw_hold_next;
         aw_addr_reg <= aw_addr_next;
         w_hold_reg <= w_hold_next;
         w_data_reg <= w_data_next;
         w_strb0_reg <= w_strb0_next;
         awready_reg <= awready_next;
         wready_reg <= wready_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         arready_reg <= arready_next;
         rvalid_reg <= rvalid_next;
         rresp_reg <= rresp_next;
         rdata_reg <= rdata_next;
         class_reg <= class_next;
         rejected_reg <= rejected_next;
      end
   end
   assign S_AXI_AWREADY = awready_reg;
   assign S_AXI_WREADY = wready_reg;
   assign S_AXI_BVALID = bvalid_reg;
   assign S_AXI_BRESP = bresp_reg;
   assign S_AXI_ARREADY = arready_reg;
   assign S_AXI_RVALID = rvalid_reg;
   assign S_AXI_RRESP = rresp_reg;
   assign S_AXI_RDATA = rdata_reg;

   // Answer engine, paced only by sampled card clock edges
   logic [15:0] cnt_reg, cnt_next;
   logic [3:0] bit_reg, bit_next;
   logic [2:0] byte_reg, byte_next;
   logic [4:0] cls_lat_reg, cls_lat_next;
   logic oe_reg, oe_next;
   logic [7:0] cur_byte;
   always_comb begin
      case (byte_reg)
         3'h0: cur_byte = card_atr_pkg::TS_DIRECT;
         3'h1: cur_byte = card_atr_pkg::T0_BYTE;
         3'h2: cur_byte = card_atr_pkg::TD1_BYTE;
         3'h3: cur_byte = card_atr_pkg::TD2_BYTE;
         3'h4: cur_byte = {3'h0, cls_lat_reg};
         default: cur_byte = card_atr_pkg::TD2_BYTE ^ {3'h0, cls_lat_reg};
      endcase
   end

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      bit_next = bit_reg;
      byte_next = byte_reg;
      cls_lat_next = cls_lat_reg;
      oe_next = 1'b0;
      case (state_reg)
         card_atr_pkg::ST_IDLE: begin
            if (card_rst_b_s) begin
               state_next = card_atr_pkg::ST_WAIT;
               cnt_next = 16'h0;
               cls_lat_next = class_reg;
            end
         end
         card_atr_pkg::ST_WAIT: begin
            if (clk_rise && cnt_reg == 16'(DELAY - 1)) begin
               state_next = card_atr_pkg::ST_SEND;
               cnt_next = 16'h0;
               bit_next = 4'h0;
               byte_next = 3'h0;
            end else if (clk_rise) begin
               cnt_next = cnt_reg + 16'h1;
            end
         end
         card_atr_pkg::ST_SEND: begin
            oe_next = !frame_bit(cur_byte, bit_reg);
            if (clk_rise && cnt_reg == 16'(ETU - 1)) begin
               cnt_next = 16'h0;
               if (bit_reg == 4'(card_atr_pkg::CHAR_BITS - 1)) begin
                  bit_next = 4'h0;
                  if (byte_reg == 3'(card_atr_pkg::ATR_LEN - 1)) begin
                     state_next = card_atr_pkg::ST_DONE;
                  end else begin
                     byte_next = byte_reg + 3'h1;
                  end
               end else begin
                  bit_next = bit_reg + 4'h1;
               end
            end else if (clk_rise) begin
               cnt_next = cnt_reg + 16'h1;
            end
         end
         card_atr_pkg::ST_DONE: begin
            state_next = card_atr_pkg::ST_DONE;
         end
         default: begin
            state_next = card_atr_pkg::ST_IDLE;
         end
      endcase
      if (!card_rst_b_s) begin
         state_next = card_atr_pkg::ST_IDLE;
         oe_next = 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         state_reg <= card_atr_pkg::ST_IDLE;
         cnt_reg <= 16'h0;
         bit_reg <= 4'h0;
         byte_reg <= 3'h0;
         cls_lat_reg <= card_atr_pkg::CLASS_RST;
         oe_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         bit_reg <= bit_next;
         byte_reg <= byte_next;
         cls_lat_reg <= cls_lat_next;
         oe_reg <= oe_next;
      end
   end
   // Open drain: pull low only, high by terminal pull-up
   assign IO_OE = oe_reg;
   assign IO_OUT = 1'b0;

   // Checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);
   AST_CLASS_ADJ: assert property (class_legal(class_reg))
      else $error("class mask not adjacent");
   AST_CLASS_BYTE: assert property (state_reg == card_atr_pkg::ST_SEND && byte_reg == 3'h4
      |-> cur_byte[7:5] == 3'h0 && cur_byte[4:0] == cls_lat_reg)
      else $error("class byte wrong");
   AST_FIRST_BYTE: assert property ($rose(state_reg == card_atr_pkg::ST_SEND)
      |-> byte_reg == 3'h0 && bit_reg == 4'h0 && cur_byte == 8'h3B)
      else $error("answer does not start with TS");
   AST_RESET_QUIET: assert property (!card_rst_b_s |=> !IO_OE ##1 !IO_OE)
      else $error("line driven under card reset");
   AST_T15_GROUP: assert property (state_reg == card_atr_pkg::ST_SEND && byte_reg == 3'h3
      |-> cur_byte[3:0] == 4'hF && cur_byte[4])
      else $error("global group missing");
   AST_CARD_PACE: assert property (state_reg == card_atr_pkg::ST_SEND && !clk_rise
      && card_rst_b_s |=> $stable(cnt_reg) && $stable(bit_reg))
      else $error("timing moved without card clock");
   AST_REJECT_SET: assert property (!class_legal(w_data_reg[4:0]) && w_strb0_reg
      && aw_hold_reg && w_hold_reg && !bvalid_reg
      && aw_addr_reg == card_atr_pkg::CLASS_ADDR
      |=> rejected_reg && $stable(class_reg))
      else $error("illegal class accepted");
   COV_DONE: cover property ($rose(state_reg == card_atr_pkg::ST_DONE));
   COV_REJECT: cover property ($rose(rejected_reg));
   COV_ABORT: cover property (state_reg == card_atr_pkg::ST_SEND ##1
      state_reg == card_atr_pkg::ST_IDLE);
endmodule
`default_nettype wire

// ### rtl/card_atr_pkg.sv
// Shared constants and types of the card answer-to-reset sender
`default_nettype none
package card_atr_pkg;
   // Register byte addresses
   localparam logic [3:0] CLASS_ADDR = 4'h0;
   localparam logic [3:0] STATUS_ADDR = 4'h4;
   // Supported class mask, bit 0 class A up to bit 4 class E
   localparam int CLS_W = 5;
   localparam logic [4:0] CLASS_RST = 5'h06;
   // Timing in card clock periods
   localparam int ETU_CLK = 372;
   localparam int ATR_DELAY_CLK = 400;
   // Character frame: start, 8 data, parity, 2 guard
   localparam int CHAR_BITS = 12;
   localparam int PARITY_BIT = 9;
   localparam int ATR_LEN = 6;
   // Fixed answer bytes: direct convention, one T=0 group, then T=15
   localparam logic [7:0] TS_DIRECT = 8'h3B;
   localparam logic [7:0] T0_BYTE = 8'h80;
   localparam logic [7:0] TD1_BYTE = 8'h80;
   localparam logic [7:0] TD2_BYTE = 8'h1F;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum {ST_IDLE, ST_WAIT, ST_SEND, ST_DONE} atr_state_t;
   typedef struct packed {
      logic io_line;
      logic rejected;
      logic done;
      logic busy;
   } status_t;
endpackage
`default_nettype wire

// ### tb/card_terminal.sv
// Terminal model: card clock, card reset, pulled-up I/O, receiver
`default_nettype none
module card_terminal #(
   parameter int ETU = 4
) (
   // Bench control
   input wire logic run,
   input wire logic act,
   // Card contacts
   input wire logic io_oe,
   output logic card_clk,
   output logic card_rst_b,
   output logic io,
   // Received bytes
   output logic [47:0] rx,
   output logic [7:0] cnt,
   output logic [7:0] perr
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] b;
   // Reset released only once the class is set
   assign card_rst_b = act;
   // Pull-up unless the card pulls low
   assign io = io_oe ? 1'b0 : 1'b1;
   // 64 ns clock, even duty, parks low when stopped
   initial begin
      card_clk = 1'b0;
      forever begin
         #32;
         if (run || card_clk) begin
            card_clk = ~card_clk;
         end
      end
   end
   // Character receiver, keeps the last six bytes received while act is high
   initial begin
      rx = '0;
      cnt = 8'h00;
      perr = 8'h00;
      b = 8'h00;
      forever begin
         @(negedge io);
         repeat (ETU / 2) @(posedge card_clk);
         if (io == 1'b0) begin
            repeat (8) begin
               repeat (ETU) @(posedge card_clk);
               b = {io, b[7:1]};
            end
            repeat (ETU) @(posedge card_clk);
            if (act) begin
               if (io !== ^b) perr = perr + 8'h01;
               rx = {rx[39:0], b};
               cnt = cnt + 8'h01;
            end
            repeat (ETU) @(posedge card_clk);
         end
      end
   end
endmodule
`default_nettype wire

// ### tb/card_voltage_class_activation_tb.sv
// Bench for the card answer-to-reset sender
`default_nettype none
module card_voltage_class_activation_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic CLK, RST_B, run, act, io_oe, io, card_clk, card_rst_b;
   logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
   logic [3:0] awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata, d;
   logic [1:0] bresp, rresp, r;
   logic [47:0] rx;
   logic [7:0] cnt, perr, base;
   logic [4:0] cls;
   logic [4:0] pats [8] = '{5'h00, 5'h05, 5'h09, 5'h0A, 5'h11, 5'h18, 5'h1F, 5'h03};
   int bad_count, checked, i;

   card_atr_sender #(.ETU(4), .DELAY(4)) uut (
      .CLK(CLK), .RST_B(RST_B), .CARD_CLK(card_clk), .CARD_RST_B(card_rst_b),
      .IO_IN(io), .IO_OUT(), .IO_OE(io_oe),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
      .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

   card_terminal #(.ETU(4)) term (
      .run(run), .act(act), .io_oe(io_oe), .card_clk(card_clk),
      .card_rst_b(card_rst_b), .io(io), .rx(rx), .cnt(cnt), .perr(perr));

   // System clock, 4 ns
   initial begin
      CLK = 1'b0;
      forever #2 CLK = ~CLK;
   end

   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
      logic aw, w;
      @(posedge CLK);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      aw = 1'b1;
      w = 1'b1;
      do begin
         @(posedge CLK);
         if (aw && awready) aw = 1'b0;
         if (w && wready) w = 1'b0;
         if (!aw) awvalid <= 1'b0;
         if (!w) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      rs = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
      @(posedge CLK);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge CLK);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      v = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask

   // Expected answer for a latched class
   function automatic logic [47:0] ans(input logic [4:0] c);
      return {8'h3B, 8'h80, 8'h80, 8'h1F, 3'h0, c, 8'h1F ^ {3'h0, c}};
   endfunction

   // Non-empty and one run of set bits
   function automatic logic legal(input logic [4:0] p);
      logic [5:0] x;
      x = {1'b0, p};
      while (x != 6'h00 && !x[0]) x = x >> 1;
      return x != 6'h00 && (x & (x + 6'h01)) == 6'h00;
   endfunction

   task automatic waitn(input logic [7:0] n);
      int k;
      for (k = 0; k < 20000 && cnt < n; k++) @(posedge CLK);
   endtask

   task automatic results;
      $display("compares %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Watchdog
   initial begin
      #150000;
      bad_count++;
      results;
   end

   // Test sequence
   initial begin
      {RST_B, run, act, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hF;
      repeat (16) @(posedge CLK);
      RST_B <= 1'b1;
      repeat (2) @(posedge CLK);
      rd(4'h0, d, r);
      chk(d, 48'h6);
      rd(4'h4, d, r);
      chk(d, 48'h8);
      rd(4'h8, d, r);
      chk({d, r}, 48'h2);
      wr(4'hC, 32'h1, r);
      chk(r, 48'h2);
      $display("test registers done");
      cls = 5'h06;
      for (i = 0; i < 8; i++) begin
         wr(4'h0, {27'h0, pats[i]}, r);
         if (legal(pats[i])) cls = pats[i];
         rd(4'h0, d, r);
         chk(d, {43'h0, cls});
         rd(4'h4, d, r);
         chk(d[2], !legal(pats[i]));
         wr(4'h4, 32'h4, r);
      end
      $display("test class patterns done");
      base = cnt;
      act <= 1'b1;
      repeat (1000) @(posedge CLK);
      chk(cnt - base, 48'h0);
      run <= 1'b1;
      waitn(base + 8'd6);
      chk(rx, ans(cls));
      // Let the last guard time pass so the sender reaches done
      repeat (200) @(posedge CLK);
      rd(4'h4, d, r);
      chk(d, 48'hA);
      $display("test first answer done");
      act <= 1'b0;
      cls = 5'h04;
      wr(4'h0, 32'h4, r);
      repeat (8) @(posedge CLK);
      act <= 1'b1;
      base = cnt;
      waitn(base + 8'd2);
      act <= 1'b0;
      repeat (1600) @(posedge CLK);
      chk(io_oe, 48'h0);
      base = cnt;
      act <= 1'b1;
      waitn(base + 8'd6);
      chk(rx, ans(cls));
      repeat (2000) @(posedge CLK);
      chk(cnt - base, 48'h6);
      chk(perr, 48'h0);
      $display("test aborted answer done");
      results;
   end
endmodule
`default_nettype wire
